// File: inc/button_pkg.sv
// shared constants for the button and run/stop switch block
package button_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PRESET_OFF = 8'h04;
  localparam logic [7:0] THRESH_OFF = 8'h08;
  localparam logic [7:0] QUERY_OFF = 8'h0C;
  localparam logic [7:0] STATUS_OFF = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h14;
  localparam logic [7:0] IRQ_EN_OFF = 8'h18;
  localparam logic [7:0] IRQ_CLR_OFF = 8'h1C;
  // control field positions
  localparam int CTRL_EDGE_A = 0;
  localparam int CTRL_EDGE_B = 1;
  localparam int CTRL_SW_ANALOG = 2;
  localparam int CTRL_W = 3;
  // status field positions
  localparam int ST_PEND = 0;
  localparam int ST_MASK = 2;
  localparam int ST_LINE = 4;
  localparam int ST_RUN = 6;
  // interrupt event bits
  localparam int EV_PRESS_A = 0;
  localparam int EV_PRESS_B = 1;
  localparam int EV_SWITCH = 2;
  localparam int EV_W = 3;
  // values after reset
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [11:0] THRESH_RST = 12'h800;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;
  // timing: debounce tick and hold-off
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int TICK_PERIOD_MS = 1;
  localparam int DEBOUNCE_MS = 180;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * CLK_FREQ_KHZ;
  localparam logic [15:0] PRESET_RST = 16'(DEBOUNCE_MS / TICK_PERIOD_MS);
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: hdl/line_sync.sv
// two-flop synchroniser for asynchronous input lines
`timescale 1ns/1ps
module line_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // lines
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// File: hdl/press_channel.sv
// one button line: detect, mask, debounce count, pending flag
`timescale 1ns/1ps
module press_channel #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // synchronised active-low line and configuration
  input wire logic line_n,
  input wire logic edge_mode,
  input wire logic [CNT_W-1:0] preset,
  // periodic tick and query clear
  input wire logic tick,
  input wire logic query_clr,
  // state
  output logic pending,
  output logic masked,
  output logic press
);
  logic prev_n_r;
  logic [CNT_W-1:0] cnt_r;
  logic hit;

  // low level, or falling edge when edge mode is chosen
  assign hit = !masked && !line_n && (!edge_mode || prev_n_r);
  assign press = hit;

  // previous line level for edge sensing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_n_r <= 1'b1;
    end else begin
      prev_n_r <= line_n;
    end
  end

  // mask and counter; ignored lows while masked never reload
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      masked <= 1'b0;
      cnt_r <= '0;
    end else if (hit) begin
      masked <= 1'b1;
      cnt_r <= preset;
    end else if (masked && tick) begin
      if (cnt_r <= CNT_W'(1)) begin
        cnt_r <= '0;
        masked <= 1'b0;
      end else begin
        cnt_r <= cnt_r - CNT_W'(1);
      end
    end
  end

  // pending flag: a new press wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending <= 1'b0;
    end else if (hit) begin
      pending <= 1'b1;
    end else if (query_clr) begin
      pending <= 1'b0;
    end
  end
endmodule

// File: hdl/button_ctrl.sv
// button press handling and run/stop switch with an AXI4-Lite slave
`timescale 1ns/1ps
// Function
// - synchronise both button lines to clock
// - each line selectable level or edge
// - keep pending flag per button line
// - line active low, low raises event
// - press masks line, loads counter, sets flag
// - tick decrements; zero unmasks line again
// - query returns flag, clears it if set
// - preset gives about 180 ms hold-off
// - gpio switch read from data bit
// - analog switch by sample threshold compare
module button_ctrl #(
  parameter int TICK_CYCLES = button_pkg::TICK_CYCLES,
  parameter int SAMPLE_W = 12,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic awvalid,
  output logic awready,
  input wire logic [button_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // write data channel
  input wire logic wvalid,
  output logic wready,
  input wire logic [button_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  // write response channel
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address channel
  input wire logic arvalid,
  output logic arready,
  input wire logic [button_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // read data channel
  output logic rvalid,
  input wire logic rready,
  output logic [button_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // button lines, active low
  input wire logic button_irq_a_n,
  input wire logic button_irq_b_n,
  // run/stop switch sources
  input wire logic run_stop_gpio,
  input wire logic [SAMPLE_W-1:0] switch_analog_input,
  input wire logic switch_analog_valid,
  // results
  output logic switch_run,
  output logic irq
);
  localparam int TCW = $clog2(TICK_CYCLES + 1);
  localparam int CW = button_pkg::CTRL_W;
  localparam int EVW = button_pkg::EV_W;

  // refuse settings the logic cannot serve
  if (TICK_CYCLES < 1 || SAMPLE_W < 1 || SAMPLE_W > 32 ||
      CNT_W < 1 || CNT_W > 32) begin : g_bad_param
    $error("button_ctrl: unsupported parameter value");
  end

  // register state
  logic [button_pkg::CTRL_W-1:0] ctrl_r;
  logic [CNT_W-1:0] preset_r;
  logic [SAMPLE_W-1:0] thresh_r;
  logic [SAMPLE_W-1:0] sample_r;
  logic gpio_data_r;
  logic switch_run_r;
  logic switch_run_nxt;
  logic [button_pkg::EV_W-1:0] irq_stat_r;
  logic [button_pkg::EV_W-1:0] irq_en_r;
  logic [button_pkg::EV_W-1:0] events;
  logic irq_r;
  // tick generator
  logic [TCW-1:0] tick_cnt_r;
  logic tick_r;
  // bus handshake state
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [button_pkg::DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_fire;
  logic rd_fire;
  logic [button_pkg::DATA_W-1:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  // channel signals
  logic [1:0] line_n;
  logic [1:0] pending;
  logic [1:0] masked;
  logic [1:0] press;
  logic [1:0] query_clr;
  logic [1:0] edge_mode;

  // word-aligned offset of a bus address
  function automatic logic [7:0] word_addr(
    input logic [button_pkg::ADDR_W-1:0] a);
    return {a[7:2], 2'h0};
  endfunction

  // merge write data into a register under byte strobes
  function automatic logic [31:0] apply_strb(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // synchronise both button lines before any detection
  line_sync #(
    .W(2),
    .RST_VAL(2'h3)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({button_irq_b_n, button_irq_a_n}),
    .sync_out(line_n)
  );

  assign edge_mode = {ctrl_r[button_pkg::CTRL_EDGE_B],
                      ctrl_r[button_pkg::CTRL_EDGE_A]};

  // one debounce channel per button line
  for (genvar g = 0; g < 2; g++) begin : g_chan
    press_channel #(
      .CNT_W(CNT_W)
    ) u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .line_n(line_n[g]),
      .edge_mode(edge_mode[g]),
      .preset(preset_r),
      .tick(tick_r),
      .query_clr(query_clr[g]),
      .pending(pending[g]),
      .masked(masked[g]),
      .press(press[g])
    );
  end

  // periodic debounce tick, one cycle wide
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TCW'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + TCW'(1);
      tick_r <= 1'b0;
    end
  end

  // handshakes complete on the cycle the ready flop is high
  assign wr_fire = awvalid && awready_r && wvalid && wready_r;
  assign rd_fire = arvalid && arready_r;

  // write channel: take address and data together, one at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
    end else if (wr_fire) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
    end else if (awvalid && wvalid && !bvalid_r) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
    end
  end

  // write decode; unmapped or read-only offsets answer with an error
  always_comb begin
    unique case (word_addr(awaddr))
      button_pkg::CTRL_OFF, button_pkg::PRESET_OFF,
      button_pkg::THRESH_OFF, button_pkg::IRQ_EN_OFF,
      button_pkg::IRQ_CLR_OFF: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= button_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? button_pkg::RESP_OKAY : button_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // configuration registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= button_pkg::CTRL_RST;
      preset_r <= CNT_W'(button_pkg::PRESET_RST);
      thresh_r <= SAMPLE_W'(button_pkg::THRESH_RST);
      irq_en_r <= button_pkg::IRQ_EN_RST;
    end else if (wr_fire) begin
      unique case (word_addr(awaddr))
        // merged word cut back to the field width on purpose
        button_pkg::CTRL_OFF:
          ctrl_r <= CW'(apply_strb(32'(ctrl_r), wdata, wstrb));
        button_pkg::PRESET_OFF:
          preset_r <= CNT_W'(apply_strb(32'(preset_r), wdata, wstrb));
        button_pkg::THRESH_OFF:
          thresh_r <= SAMPLE_W'(apply_strb(32'(thresh_r), wdata, wstrb));
        button_pkg::IRQ_EN_OFF:
          irq_en_r <= EVW'(apply_strb(32'(irq_en_r), wdata, wstrb));
        default: ;
      endcase
    end
  end

  // read channel: one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
    end else if (rd_fire) begin
      arready_r <= 1'b0;
    end else if (arvalid && !rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  // read mux; query shows pending flags, status shows live state
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    unique case (word_addr(araddr))
      button_pkg::CTRL_OFF: rd_word = 32'(ctrl_r);
      button_pkg::PRESET_OFF: rd_word = 32'(preset_r);
      button_pkg::THRESH_OFF: rd_word = 32'(thresh_r);
      button_pkg::QUERY_OFF: rd_word = 32'(pending);
      button_pkg::STATUS_OFF: begin
        rd_word[button_pkg::ST_PEND +: 2] = pending;
        rd_word[button_pkg::ST_MASK +: 2] = masked;
        rd_word[button_pkg::ST_LINE +: 2] = line_n;
        rd_word[button_pkg::ST_RUN] = switch_run_r;
      end
      button_pkg::IRQ_STAT_OFF: rd_word = 32'(irq_stat_r);
      button_pkg::IRQ_EN_OFF: rd_word = 32'(irq_en_r);
      default: rd_hit = 1'b0;
    endcase
  end

  // a query read clears only flags that it reported as set
  assign query_clr = (rd_fire && word_addr(araddr) == button_pkg::QUERY_OFF)
                     ? pending : 2'h0;

  // read data held until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= button_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_hit ? button_pkg::RESP_OKAY : button_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // switch sources: gpio data bit and latched analog sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_data_r <= 1'b0;
      sample_r <= '0;
    end else begin
      gpio_data_r <= run_stop_gpio;
      if (switch_analog_valid) begin
        sample_r <= switch_analog_input;
      end
    end
  end

  // run state: at or above threshold counts as run
  always_comb begin
    if (ctrl_r[button_pkg::CTRL_SW_ANALOG]) begin
      switch_run_nxt = (sample_r >= thresh_r);
    end else begin
      switch_run_nxt = gpio_data_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      switch_run_r <= 1'b0;
    end else begin
      switch_run_r <= switch_run_nxt;
    end
  end

  // events: each accepted press and each switch change
  assign events = {switch_run_nxt != switch_run_r, press};

  // sticky status; a new event wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
    end else begin
      for (int i = 0; i < button_pkg::EV_W; i++) begin
        if (events[i]) begin
          irq_stat_r[i] <= 1'b1;
        end else if (wr_fire && wstrb[0] &&
                     word_addr(awaddr) == button_pkg::IRQ_CLR_OFF &&
                     wdata[i]) begin
          irq_stat_r[i] <= 1'b0;
        end
      end
    end
  end

  // level interrupt from enabled sticky bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  // outputs straight from flops
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign switch_run = switch_run_r;
  assign irq = irq_r;
endmodule

// File: testbench/button_ctrl_assertions.sv
// port checker for the button block
`timescale 1ns/1ps
module button_ctrl_assertions #(
  parameter int SAMPLE_W = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [button_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [button_pkg::DATA_W-1:0] wdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [button_pkg::DATA_W-1:0] rdata,
  // switch and results
  input wire logic run_stop_gpio,
  input wire logic [SAMPLE_W-1:0] switch_analog_input,
  input wire logic switch_analog_valid,
  input wire logic switch_run,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic an_r;
  logic [2:0] en_r;
  logic [SAMPLE_W-1:0] th_r;
  logic [SAMPLE_W-1:0] smp_r;
  sequence wr_hs_s;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_hs_s;
    arvalid && arready;
  endsequence
  // shadow of the configuration, so mode-dependent checks know the mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      an_r <= 1'b0;
      en_r <= button_pkg::IRQ_EN_RST;
      th_r <= SAMPLE_W'(button_pkg::THRESH_RST);
    end else if (awvalid && awready && wvalid && wready) begin
      if (awaddr == button_pkg::CTRL_OFF) an_r <= wdata[2];
      if (awaddr == button_pkg::IRQ_EN_OFF) en_r <= wdata[2:0];
      if (awaddr == button_pkg::THRESH_OFF) th_r <= wdata[SAMPLE_W-1:0];
    end
  end
  // latched sample as the block should see it
  always_ff @(posedge aclk) begin
    if (switch_analog_valid) smp_r <= switch_analog_input;
  end
  wr_pair_a: assert property (awready == wready)
    else $error("write readies split");
  aw_cause_a: assert property (awready |-> awvalid && wvalid && !bvalid)
    else $error("write ready without request");
  wr_resp_a: assert property (wr_hs_s |=> bvalid)
    else $error("no write response");
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  rd_resp_a: assert property (rd_hs_s |=> rvalid)
    else $error("no read response");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped");
  gpio_run_a: assert property (
    (!an_r && $stable(run_stop_gpio))[*3] |-> switch_run == run_stop_gpio)
    else $error("switch differs from gpio");
  analog_run_a: assert property (
    an_r && switch_analog_valid |=> ##[1:2] switch_run == (smp_r >= th_r))
    else $error("switch differs from compare");
  irq_en_a: assert property (irq |-> $past(en_r) != 3'h0)
    else $error("irq while all disabled");
endmodule
bind button_ctrl button_ctrl_assertions #(.SAMPLE_W(SAMPLE_W)) chk_u (
  .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
  .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
  .run_stop_gpio, .switch_analog_input, .switch_analog_valid, .switch_run,
  .irq);

// File: testbench/button_model.sv
// push buttons with contact chatter and a run/stop switch
`timescale 1ns/1ps
module button_model (
  // clock
  input wire logic aclk,
  // commands from the bench
  input wire logic [1:0] press,
  input wire logic run,
  input wire logic [11:0] level,
  input wire logic conv,
  // contacts and converter
  output logic [1:0] line_n,
  output logic gpio,
  output logic [11:0] sample,
  output logic sample_valid
);
  logic [1:0] prev_r = 2'h0;
  logic [1:0] chg_r = 2'h0;
  logic [3:0] bounce_r = 4'h0;
  initial begin
    line_n = 2'h3;
    gpio = 1'b0;
    sample = 12'h0;
    sample_valid = 1'b0;
  end
  // a changed contact chatters seven cycles; lines are pulled up
  always @(posedge aclk) begin
    prev_r <= press;
    if (press != prev_r) begin
      bounce_r <= 4'h7;
      chg_r <= press ^ prev_r;
    end else if (bounce_r != 4'h0) begin
      bounce_r <= bounce_r - 4'h1;
    end
    line_n <= ~press ^ (bounce_r[0] ? chg_r : 2'h0);
    gpio <= run;
    sample_valid <= conv;
    sample <= conv ? level : ~sample; // between conversions the sample inverts every cycle, so it is never held
  end
endmodule

// File: testbench/test_button_ctrl.sv
// self-checking bench for the button and switch block
`timescale 1ns/1ps
module test_button_ctrl;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, run = 1'b0, conv = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, switch_run, irq;
  logic gpio, s_valid;
  logic [1:0] bresp, rresp, line_n, press = 2'h0;
  logic [11:0] level = 12'h0, sample, s;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  int n_errors = 0, checked = 0, cyc = 0;
  always #12.5 aclk = ~aclk;
  button_ctrl #(.TICK_CYCLES(8)) dut_u (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
    .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
    .rdata, .rresp, .button_irq_a_n(line_n[0]),
    .button_irq_b_n(line_n[1]), .run_stop_gpio(gpio),
    .switch_analog_input(sample), .switch_analog_valid(s_valid),
    .switch_run, .irq);
  button_model model_u (.aclk, .press, .run, .level, .conv, .line_n,
    .gpio, .sample, .sample_valid(s_valid));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'h0);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    bq.push_back(r);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    // each channel is released at the edge that takes it
    do begin
      @(posedge aclk);
      if (awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    // bready stays high, so back-to-back calls never toggle it twice
    do @(posedge aclk); while (!bvalid);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input logic [1:0] r = 2'h0);
    rq.push_back({m, r, e});
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
  endtask
  // each answer is paired with the oldest note
  always @(posedge aclk) begin
    logic [65:0] e;
    if (bvalid && bready) check({30'h0, bresp}, {30'h0, bq.pop_front()});
    if (rvalid && rready) begin
      e = rq.pop_front();
      check(rdata & e[65:34], e[31:0]);
      check({30'h0, rresp}, {30'h0, e[33:32]});
    end
  end
  // hang guard, well above the roughly 1000 cycles needed
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    void'($urandom(25));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(button_pkg::CTRL_OFF, 32'h7, 32'h0);
    rd(button_pkg::PRESET_OFF, 32'hFFFF, 32'hB4);
    rd(button_pkg::THRESH_OFF, 32'hFFF, 32'h800);
    rd(button_pkg::IRQ_STAT_OFF, 32'h7, 32'h0);
    rd(8'h20, 32'hFFFFFFFF, 32'h0, button_pkg::RESP_SLVERR);
    wr(button_pkg::STATUS_OFF, 32'h0, button_pkg::RESP_SLVERR);
    s = 12'($urandom);
    wr(button_pkg::THRESH_OFF, {20'h0, s});
    rd(button_pkg::THRESH_OFF, 32'hFFF, {20'h0, s});
    wr(button_pkg::PRESET_OFF, 32'h8); // long enough for the reads below
    wr(button_pkg::IRQ_EN_OFF, 32'h7);
    rd(button_pkg::IRQ_EN_OFF, 32'h7, 32'h7);
    $display("registers done");
    for (int b = 0; b < 2; b++) begin
      press[b] <= 1'b1;
      repeat (12) @(posedge aclk);
      rd(button_pkg::STATUS_OFF, 32'h5 << b, 32'h5 << b);
      check({31'h0, irq}, 32'h1);
      rd(button_pkg::QUERY_OFF, 32'h1 << b, 32'h1 << b);
      rd(button_pkg::QUERY_OFF, 32'h1 << b, 32'h0);
      wr(button_pkg::IRQ_CLR_OFF, 32'h7);
      rd(button_pkg::IRQ_STAT_OFF, 32'h1 << b, 32'h0);
      check({31'h0, irq}, 32'h0);
      repeat (80) @(posedge aclk);
      rd(button_pkg::STATUS_OFF, 32'h10 << b, 32'h0);
      rd(button_pkg::QUERY_OFF, 32'h1 << b, 32'h1 << b);
      press[b] <= 1'b0;
      repeat (80) @(posedge aclk);
      rd(button_pkg::QUERY_OFF, 32'h3, 32'h0);
      wr(button_pkg::CTRL_OFF, 32'h1 << b);
      press[b] <= 1'b1;
      repeat (80) @(posedge aclk);
      rd(button_pkg::QUERY_OFF, 32'h1 << b, 32'h1 << b);
      repeat (80) @(posedge aclk);
      rd(button_pkg::QUERY_OFF, 32'h1 << b, 32'h0);
      press[b] <= 1'b0;
      repeat (80) @(posedge aclk);
      rd(button_pkg::STATUS_OFF, 32'h10 << b, 32'h10 << b);
      wr(button_pkg::CTRL_OFF, 32'h0);
      // release chatter is a fresh falling edge once unmasked
      rd(button_pkg::QUERY_OFF, 32'h3, 32'h1 << b);
      wr(button_pkg::IRQ_CLR_OFF, 32'h7);
      $display("button %0d done", b);
    end
    run <= 1'b1;
    repeat (5) @(posedge aclk);
    check({31'h0, switch_run}, 32'h1);
    rd(button_pkg::IRQ_STAT_OFF, 32'h4, 32'h4);
    run <= 1'b0;
    repeat (5) @(posedge aclk);
    check({31'h0, switch_run}, 32'h0);
    wr(button_pkg::THRESH_OFF, 32'h800);
    wr(button_pkg::CTRL_OFF, 32'h4);
    for (int i = 0; i < 6; i++) begin
      s = (i == 0) ? 12'h800 : (i == 1) ? 12'h7FF : 12'($urandom);
      level <= s;
      conv <= 1'b1;
      @(posedge aclk);
      conv <= 1'b0;
      repeat (5) @(posedge aclk);
      check({31'h0, switch_run}, {31'h0, s >= 12'h800});
    end
    $display("switch done");
    conclude();
  end
endmodule
